// >>> hw/msc_stat_counters.sv
`include "msc_defs.svh"

module msc_stat_counters (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic rx_dv,
  input wire logic rx_er,
  input wire logic [7:0] rxd,
  input wire logic link_is_1000,
  input wire logic rx_frame_end,
  input wire logic [14:0] rx_frame_len,
  input wire logic rx_filter_pass,
  input wire logic rx_stored,
  input wire logic rx_crc_bad,
  input wire logic rx_fifo_drop,
  input wire logic rx_fc_addr_match,
  input wire logic rx_fc_type_match,
  input wire logic rx_fc_is_xon,
  input wire logic rx_fc_is_xoff,
  input wire logic tx_xon_sent,
  input wire logic tx_xoff_sent,
  output logic rx_total_pulse
);

  msc_pkg::msc_state_t s_reg;
  msc_pkg::msc_state_t s_next;

  logic rx_on;
  logic tx_on;
  logic len_ge_min;
  logic len_legal;
  logic [14:0] max_len;
  logic er_any;
  logic is_fc;
  logic setup;
  logic wr_take;
  logic hit;
  logic [3:0] hit_idx;
  logic [31:0] rd_val;
  logic [`MSC_NCNT-1:0] inc;
  logic [`MSC_NCNT-1:0] rd_clr;
  logic [1:0] int_set;

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  always_comb begin
    hit = 1'b1;
    hit_idx = 4'hf;
    rd_val = 32'h0000_0000;
    case (paddr)
      `MSC_OFS_CRC_ERROR_COUNT: hit_idx = 4'(msc_pkg::MSC_CRC);
      `MSC_OFS_RX_SYMBOL_ERROR_COUNT: hit_idx = 4'(msc_pkg::MSC_SYM);
      `MSC_OFS_MISSED_PACKET_COUNT: hit_idx = 4'(msc_pkg::MSC_MISS);
      `MSC_OFS_CARRIER_EXT_ERROR_COUNT: hit_idx = 4'(msc_pkg::MSC_CEXT);
      `MSC_OFS_RESUME_FRAMES_RECEIVED: hit_idx = 4'(msc_pkg::MSC_XON_RX);
      `MSC_OFS_RESUME_FRAMES_SENT: hit_idx = 4'(msc_pkg::MSC_XON_TX);
      `MSC_OFS_PAUSE_FRAMES_RECEIVED: hit_idx = 4'(msc_pkg::MSC_XOFF_RX);
      `MSC_OFS_PAUSE_FRAMES_SENT: hit_idx = 4'(msc_pkg::MSC_XOFF_TX);
      `MSC_OFS_UNSUPPORTED_FC_FRAME_COUNT: begin
        hit_idx = 4'(msc_pkg::MSC_FC_UNSUP);
      end
      `MSC_OFS_GOOD_PACKETS_RECEIVED: begin
        hit_idx = 4'(msc_pkg::MSC_GOOD_RX);
      end
      `MSC_OFS_CONTROL: rd_val = {29'h0, s_reg.ctrl};
      `MSC_OFS_INT_STATUS: rd_val = {30'h0, s_reg.status};
      `MSC_OFS_INT_MASK: rd_val = {30'h0, s_reg.mask};
      default: hit = 1'b0;
    endcase
    if (hit_idx != 4'hf) begin
      rd_val = s_reg.cnt[hit_idx];
    end
  end

  // ------------------------------------------------------------
  // Event qualification
  // ------------------------------------------------------------
  always_comb begin
    rx_on = s_reg.ctrl[`MSC_CTRL_RX_EN];
    tx_on = s_reg.ctrl[`MSC_CTRL_TX_EN];
    max_len = s_reg.ctrl[`MSC_CTRL_JUMBO] ? `MSC_MAX_LEN_JUMBO
                                          : `MSC_MAX_LEN_STD;
    len_ge_min = rx_frame_len >= `MSC_MIN_LEN;
    len_legal = len_ge_min && (rx_frame_len <= max_len);
    er_any = s_reg.er_seen | (rx_dv & rx_er);
    is_fc = rx_fc_addr_match & rx_fc_type_match;
    inc = '0;
    // Receive side gated by enable
    inc[msc_pkg::MSC_CRC] = rx_on & rx_frame_end & rx_filter_pass &
                            len_ge_min & rx_crc_bad;
    inc[msc_pkg::MSC_SYM] = rx_on & rx_frame_end & rx_filter_pass &
                            len_ge_min & er_any;
    inc[msc_pkg::MSC_MISS] = rx_on & rx_frame_end & rx_fifo_drop;
    inc[msc_pkg::MSC_CEXT] = rx_on & link_is_1000 & !rx_dv & rx_er &
                             (rxd == `MSC_CEXT_ERR_CODE) &
                             !s_reg.ext_seen;
    // Stored frames only
    inc[msc_pkg::MSC_XON_RX] = rx_on & rx_frame_end & rx_stored & is_fc &
                               rx_fc_is_xon;
    inc[msc_pkg::MSC_XOFF_RX] = rx_on & rx_frame_end & rx_stored & is_fc &
                                rx_fc_is_xoff;
    inc[msc_pkg::MSC_FC_UNSUP] = rx_on & rx_frame_end & rx_stored & is_fc &
                                 !rx_fc_is_xon &
                                 !rx_fc_is_xoff;
    inc[msc_pkg::MSC_GOOD_RX] = rx_on & rx_frame_end & rx_stored &
                                rx_filter_pass & len_legal & !rx_crc_bad &
                                !er_any & !rx_fifo_drop &
                                !is_fc;
    inc[msc_pkg::MSC_XON_TX] = tx_on & tx_xon_sent;
    inc[msc_pkg::MSC_XOFF_TX] = tx_on & tx_xoff_sent;
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    setup = psel & !penable;
    wr_take = psel & penable & pwrite & s_reg.pready;
    rd_clr = '0;
    int_set = 2'h0;
    if (setup && !pwrite && hit_idx != 4'hf) begin
      rd_clr[hit_idx] = 1'b1;
    end
    // Counters update in the cycle after the event
    for (int i = 0; i < `MSC_NCNT; i++) begin
      if (rd_clr[i]) begin
        // Old value goes out, colliding event kept
        s_next.cnt[i] = inc[i] ? 32'h0000_0001 : `MSC_CNT_RESET;
      end else if (inc[i]) begin
        if (s_reg.cnt[i] != `MSC_CNT_SAT) begin
          s_next.cnt[i] = s_reg.cnt[i] + 32'h0000_0001;
        end else begin
          int_set[`MSC_INT_SATURATED] = 1'b1;
        end
      end
    end
    int_set[`MSC_INT_OVERRUN] = inc[msc_pkg::MSC_MISS];
    // Per-frame error flags
    if (rx_frame_end) begin
      s_next.er_seen = 1'b0;
      s_next.ext_seen = 1'b0;
    end else begin
      s_next.er_seen = er_any;
      s_next.ext_seen = s_reg.ext_seen | inc[msc_pkg::MSC_CEXT];
    end
    // Missed frames still feed totals
    s_next.rx_total_pulse = rx_on & rx_frame_end;
    // Register writes
    if (wr_take) begin
      case (paddr)
        `MSC_OFS_CONTROL: s_next.ctrl = pwdata[2:0];
        `MSC_OFS_INT_STATUS: s_next.status = s_reg.status & ~pwdata[1:0];
        `MSC_OFS_INT_MASK: s_next.mask = pwdata[1:0];
        default: s_next.ctrl = s_reg.ctrl;
      endcase
    end
    // Set wins over clear
    s_next.status = s_next.status | int_set;
    s_next.irq = |(s_next.status & s_next.mask);
    // Bus answer
    s_next.pready = setup;
    s_next.pslverr = setup & !hit;
    if (setup) begin
      s_next.prdata = pwrite ? 32'h0000_0000 : rd_val;
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      s_reg.ctrl <= `MSC_CTRL_RESET;
      s_reg.status <= `MSC_INT_RESET;
      s_reg.mask <= `MSC_INT_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign irq = s_reg.irq;
  assign rx_total_pulse = s_reg.rx_total_pulse;

endmodule

// >>> hw/msc_defs.svh
// What this block does
// - Software read returns count, then clears it
// - Counters stick at all ones until read
// - Flow control and good frame receive counts once stored in packet buffer
// - Events visible in count within one microsecond
// - CRC errors: filtered, 64 bytes or longer
// - Symbol errors: filtered, 64 bytes or longer
// - Dropped for full FIFO counts, sets overrun
// - Missed packets still reach total packet count
// - Extension error code counts at gigabit only
// - Resume frames received, matching address, receive on
// - Resume frames sent, any cause, transmit on
// - Pause frames received, matching address, receive on
// - Pause frames sent, any cause, transmit on
// - Matching type with bad opcode counts unsupported
// - Good frames: legal length, filtered, no control
// - Receiver disabled blocks every receive counter
`ifndef MSC_DEFS_SVH
`define MSC_DEFS_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define MSC_OFS_CRC_ERROR_COUNT 16'h4000
`define MSC_OFS_RX_SYMBOL_ERROR_COUNT 16'h400c
`define MSC_OFS_MISSED_PACKET_COUNT 16'h4010
`define MSC_OFS_CARRIER_EXT_ERROR_COUNT 16'h403c
`define MSC_OFS_RESUME_FRAMES_RECEIVED 16'h4048
`define MSC_OFS_RESUME_FRAMES_SENT 16'h404c
`define MSC_OFS_PAUSE_FRAMES_RECEIVED 16'h4050
`define MSC_OFS_PAUSE_FRAMES_SENT 16'h4054
`define MSC_OFS_UNSUPPORTED_FC_FRAME_COUNT 16'h4058
`define MSC_OFS_GOOD_PACKETS_RECEIVED 16'h4074
`define MSC_OFS_CONTROL 16'h40f0
`define MSC_OFS_INT_STATUS 16'h40f4
`define MSC_OFS_INT_MASK 16'h40f8

// ------------------------------------------------------------
// Fields and reset values
// ------------------------------------------------------------
`define MSC_CTRL_RX_EN 0
`define MSC_CTRL_TX_EN 1
`define MSC_CTRL_JUMBO 2
`define MSC_INT_OVERRUN 0
`define MSC_INT_SATURATED 1
`define MSC_CTRL_RESET 3'h0
`define MSC_INT_RESET 2'h0
`define MSC_CNT_RESET 32'h0000_0000
`define MSC_CNT_SAT 32'hffff_ffff
`define MSC_NCNT 10

// ------------------------------------------------------------
// Frame lengths and codes
// ------------------------------------------------------------
`define MSC_MIN_LEN 15'h0040
`define MSC_MAX_LEN_STD 15'h05f2
`define MSC_MAX_LEN_JUMBO 15'h4000
`define MSC_CEXT_ERR_CODE 8'h1f

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define MSC_CLK_PERIOD_NS 40
`define MSC_EVENT_VISIBLE_NS 1000
`define MSC_EVENT_VISIBLE_CYCLES \
  (`MSC_EVENT_VISIBLE_NS / `MSC_CLK_PERIOD_NS)

`endif

// >>> hw/msc_pkg.sv
`include "msc_defs.svh"

package msc_pkg;

  typedef enum logic [3:0] {
    MSC_CRC,
    MSC_SYM,
    MSC_MISS,
    MSC_CEXT,
    MSC_XON_RX,
    MSC_XON_TX,
    MSC_XOFF_RX,
    MSC_XOFF_TX,
    MSC_FC_UNSUP,
    MSC_GOOD_RX
  } msc_cnt_idx_t;

  typedef struct packed {
    logic [`MSC_NCNT-1:0][31:0] cnt;
    logic [2:0] ctrl;
    logic [1:0] status;
    logic [1:0] mask;
    logic er_seen;
    logic ext_seen;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic rx_total_pulse;
  } msc_state_t;

endpackage

// >>> testbench/msc_stat_counters_assertions.sv
module msc_sc_checker (
  input wire logic pclk, presetn, psel, penable, pwrite, pready,
  input wire logic pslverr, irq, rx_frame_end, tx_xon_sent,
  input wire logic tx_xoff_sent, rx_total_pulse,
  input wire logic [15:0] paddr,
  input wire logic [31:0] prdata
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ----
  // Bus and event checks
  // ----
  setup_ans_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_once_a: assert property (pready |=> !pready)
    else $error("ready held");
  ready_cause_a: assert property (pready |-> $past(psel && !penable))
    else $error("ready without setup");
  err_blank_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error reply with data");
  hole_err_a: assert property (psel && !penable && paddr == 16'h4004
    |=> pslverr) else $error("hole not refused");
  rdata_hold_a: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("read data moved");
  total_cause_a: assert property (rx_total_pulse |-> $past(rx_frame_end))
    else $error("total pulse without frame");
  total_quiet_a: assert property (!rx_frame_end |=> !rx_total_pulse)
    else $error("stray total pulse");
  irq_cause_a: assert property ($rose(irq) |-> $past(rx_frame_end ||
    tx_xon_sent || tx_xoff_sent || psel)) else $error("irq without cause");
  read_c: cover property (pready && !pwrite);
  total_c: cover property (rx_total_pulse);
  irq_c: cover property ($rose(irq));
endmodule

bind msc_stat_counters msc_sc_checker msc_sc_checker_inst (.*);

// >>> testbench/msc_mac_model.sv
module msc_mac_model (
  input wire logic pclk,
  output logic rx_dv, rx_er, link_is_1000, rx_frame_end,
  output logic [7:0] rxd,
  output logic [14:0] rx_frame_len,
  output logic rx_filter_pass, rx_stored, rx_crc_bad, rx_fifo_drop,
  output logic rx_fc_addr_match, rx_fc_type_match, rx_fc_is_xon,
  output logic rx_fc_is_xoff, tx_xon_sent, tx_xoff_sent
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] fl;
  assign {rx_filter_pass, rx_stored, rx_crc_bad, rx_fifo_drop,
    rx_fc_addr_match, rx_fc_type_match, rx_fc_is_xon, rx_fc_is_xoff} = fl;
  initial begin
    {rx_dv, rx_er, rx_frame_end, tx_xon_sent, tx_xoff_sent} = 5'h0;
    link_is_1000 = 1'b1;
    rxd = 8'h0;
    rx_frame_len = 15'h0;
    fl = 8'h0;
  end
  // ----
  // Frame end, attributes invert once stale
  // ----
  task automatic frame(input logic [14:0] len, input logic [7:0] f);
    @(posedge pclk);
    rx_frame_end <= 1'b1;
    rx_frame_len <= len;
    fl <= f;
    @(posedge pclk);
    rx_frame_end <= 1'b0;
    rx_frame_len <= ~len;
    fl <= ~f;
  endtask
  task automatic gmii(input logic dv, er, input logic [7:0] d);
    @(posedge pclk);
    {rx_dv, rx_er, rxd} <= {dv, er, d};
    @(posedge pclk);
    {rx_dv, rx_er, rxd} <= {2'h0, ~d};
  endtask
  task automatic tx(input logic xon, xoff);
    @(posedge pclk);
    {tx_xon_sent, tx_xoff_sent} <= {xon, xoff};
    @(posedge pclk);
    {tx_xon_sent, tx_xoff_sent} <= 2'h0;
  endtask
endmodule

// >>> testbench/msc_stat_counters_tb_top.sv
module msc_stat_counters_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata;
  logic rx_dv, rx_er, link_is_1000, rx_frame_end, rx_filter_pass;
  logic rx_stored, rx_crc_bad, rx_fifo_drop, rx_fc_addr_match;
  logic rx_fc_type_match, rx_fc_is_xon, rx_fc_is_xoff, tx_xon_sent;
  logic tx_xoff_sent, rx_total_pulse;
  logic [7:0] rxd, lfsr;
  logic [14:0] rx_frame_len;
  logic [32:0] exp_q[$];
  int error_cnt, compares, cyc;
  logic [15:0] ofs [10] = '{16'h4000, 16'h400c, 16'h4010, 16'h403c,
    16'h4048, 16'h404c, 16'h4050, 16'h4054, 16'h4058, 16'h4074};
  msc_stat_counters msc_stat_counters_inst (.*);
  msc_mac_model msc_mac_model_inst (.*);
  always #20 pclk = ~pclk;
  // ----
  // Shared tasks
  // ----
  function automatic logic [7:0] nx(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input logic [32:0] g, e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic wrap_up();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [15:0] a,
                      input logic [31:0] d, input logic [32:0] e);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    if (!w) exp_q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && n++ < 50);
    if (pready !== 1'b1) begin
      error_cnt++;
      $display("[FAIL] %0t no ready from slave", $time);
    end
    {psel, penable} <= 2'h0;
  endtask
  task automatic rd_all(input logic [31:0] v, g);
    for (int i = 0; i < 10; i++) xfer(1'b0, ofs[i], 32'h0, {1'b0, i == 9 ? g : v});
  endtask
  task automatic burst();
    msc_mac_model_inst.frame(15'h0040, 8'he0);
    msc_mac_model_inst.frame(15'h003f, 8'he0);
    for (int i = 0; i < 4; i++) begin
      lfsr = nx(lfsr);
      msc_mac_model_inst.frame(15'h0040 + {5'h0, lfsr, 2'h0}, 8'hc0);
    end
    msc_mac_model_inst.frame(15'h0064, 8'h80);
    msc_mac_model_inst.frame(15'h0064, 8'hd0);
    msc_mac_model_inst.frame(15'h0040, 8'hce);
    msc_mac_model_inst.frame(15'h0040, 8'hcd);
    msc_mac_model_inst.frame(15'h0040, 8'hcc);
    msc_mac_model_inst.gmii(1'b1, 1'b1, 8'h55);
    msc_mac_model_inst.frame(15'h0040, 8'hc0);
    msc_mac_model_inst.gmii(1'b0, 1'b1, 8'h1f);
    msc_mac_model_inst.frame(15'h0040, 8'h00);
    msc_mac_model_inst.tx(1'b1, 1'b0);
    msc_mac_model_inst.tx(1'b0, 1'b1);
    repeat (4) @(negedge pclk);
  endtask
  // ----
  // Read monitor and timeout
  // ----
  always @(negedge pclk) begin
    if (pready === 1'b1 && pwrite === 1'b0) begin
      if (exp_q.size() == 0) chk(33'h1, 33'h0);
      else chk({pslverr, prdata}, exp_q.pop_front());
    end
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end
  initial begin
    {pclk, presetn, psel, penable, pwrite} = 5'h0;
    paddr = 16'h0;
    pwdata = 32'h0;
    lfsr = 8'h53;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd_all(32'h0, 32'h0);
    xfer(1'b1, 16'h4000, 32'h5, 33'h0);
    xfer(1'b0, 16'h4000, 32'h0, 33'h0);
    xfer(1'b0, 16'h4004, 32'h0, {1'b1, 32'h0});
    xfer(1'b1, 16'h40f8, 32'h1, 33'h0);
    xfer(1'b1, 16'h40f0, 32'h3, 33'h0);
    burst();
    chk({32'h0, irq}, 33'h1);
    xfer(1'b0, 16'h40f4, 32'h0, 33'h1);
    xfer(1'b1, 16'h40f4, 32'h1, 33'h0);
    repeat (2) @(negedge pclk);
    chk({32'h0, irq}, 33'h0);
    rd_all(32'h1, 32'h4);
    rd_all(32'h0, 32'h0);
    xfer(1'b1, 16'h40f0, 32'h0, 33'h0);
    burst();
    rd_all(32'h0, 32'h0);
    xfer(1'b1, 16'h40f0, 32'h3, 33'h0);
    msc_mac_model_inst.tx(1'b1, 1'b0);
    fork
      xfer(1'b0, 16'h404c, 32'h0, 33'h1);
      msc_mac_model_inst.tx(1'b1, 1'b0);
    join
    xfer(1'b0, 16'h404c, 32'h0, 33'h1);
    repeat (2) @(posedge pclk);
    wrap_up();
  end
endmodule
